// *** include/dbgsr_map.svh ***
// register offsets, field positions, reset values for the debug status block
`ifndef DBGSR_MAP_SVH
`define DBGSR_MAP_SVH
`define DBGSR_ADDR_STATUS 8'h00
`define DBGSR_ADDR_INST 8'h04
`define DBGSR_ADDR_PC 8'h08
`define DBGSR_ADDR_CTRL 8'h0C
`define DBGSR_BIT_TBF 28
`define DBGSR_BIT_EXT 27
`define DBGSR_BIT_REQ 26
`define DBGSR_BIT_ZOP 25
`define DBGSR_BIT_IDLE 24
`define DBGSR_BP_LO 8
`define DBGSR_BIT_IN_DBG 5
`define DBGSR_BIT_SLEEP 4
`define DBGSR_BIT_HWB 2
`define DBGSR_BIT_SWB 1
`define DBGSR_BIT_SSTEP 0
`define DBGSR_CTRL_IRP 23
`define DBGSR_CTRL_TOZ 25
`define DBGSR_RESET_WORD 32'h0000_0000
`define DBGSR_ZERO_OPCODE 16'h0000
`endif

// *** include/dbgsr_pkg.sv ***
// types for the debug status block
package dbgsr_pkg;
  typedef enum logic {DBGSR_RUN, DBGSR_HALT} dbgsr_mode_type;
endpackage : dbgsr_pkg

// *** verilog/dbgsr_top.sv ***
// debug status, instruction and sampled pc registers
`timescale 1ns/1ps
`include "dbgsr_map.svh"
// Function
// - status word read-only; simultaneous causes all set together
// - status content undefined outside debug mode
// - bit 28 set on entry by trace buffer full, cleared on exit
// - bit 27 set on entry by event-in pin, cleared on exit
// - bit 26 set on entry by debug request, cleared on exit
// - bit 25 set on entry by zero opcode, cleared on exit
// - bit 24 one only in debug mode with no instruction executing
// - bits 15:8 flag matching breakpoint comparators, cleared on exit
// - bit 5 one in debug mode, zero otherwise including monitor mode
// - bit 4 set on entry from sleep, cleared on exit
// - bit 2 set on hardware breakpoint entry, cleared on exit
// - bit 1 set on breakpoint instruction entry, cleared on exit
// - bit 0 set on single-step entry, cleared on exit
// - status bits driven from core state; writes ignored
// - 32-bit read/write instruction register feeds halted core, resets zero
// - core consumes debug instructions faster than writes; no back-pressure
// - instruction register also holds instruction replacing software breakpoint
// - sampled pc tracks last executed address outside debug mode
// - sampled pc frozen during debug mode except for register port writes
// - core uses sampled pc for a replaced return instruction
// - replace bit makes first post-return fetch come from instruction register
// - trap-zero bit makes zero opcode force debug entry
module dbgsr_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // debugger register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // core debug entry and causes
  input wire logic debug_enter,
  input wire logic debug_exit,
  input wire logic monitor_mode,
  input wire logic trace_buffer_full_cause,
  input wire logic event_in_pin,
  input wire logic debug_request,
  input wire logic hw_breakpoint_cause,
  input wire logic [7:0] breakpoint_hit_vector,
  input wire logic sw_breakpoint_cause,
  input wire logic single_step_cause,
  input wire logic core_sleeping,
  // core execution state
  input wire logic instr_retire,
  input wire logic [31:0] instr_pc,
  input wire logic [15:0] instr_opcode,
  input wire logic dbg_instr_busy,
  input wire logic dbg_fetch,
  input wire logic return_fetch,
  // core controls
  output logic zero_opcode_trap,
  output logic fetch_from_debug_word,
  output logic [31:0] debug_instruction_word,
  output logic [31:0] debug_sampled_pc
);
  // ----------------------------------------------------------------
  // event-in pin synchroniser and falling edge
  // ----------------------------------------------------------------
  logic evt_s1_reg;
  logic evt_s2_reg;
  logic evt_s3_reg;
  logic evt_fall;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_s1_reg <= 1'b1;
      evt_s2_reg <= 1'b1;
      evt_s3_reg <= 1'b1;
    end else begin
      evt_s1_reg <= event_in_pin;
      evt_s2_reg <= evt_s1_reg;
      evt_s3_reg <= evt_s2_reg;
    end
  end
  assign evt_fall = evt_s3_reg & ~evt_s2_reg;

  // ----------------------------------------------------------------
  // debug mode state
  // ----------------------------------------------------------------
  dbgsr_pkg::dbgsr_mode_type mode_reg;
  logic zero_hit;
  logic entering;
  logic in_dbg;
  assign in_dbg = (mode_reg == dbgsr_pkg::DBGSR_HALT);
  // monitor-mode handling never enters halt
  assign entering = !in_dbg && !monitor_mode && (debug_enter || zero_hit || evt_fall);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= dbgsr_pkg::DBGSR_RUN;
    end else begin
      unique case (mode_reg)
        dbgsr_pkg::DBGSR_RUN: begin
          if (entering) begin
            mode_reg <= dbgsr_pkg::DBGSR_HALT;
          end
        end
        dbgsr_pkg::DBGSR_HALT: begin
          if (debug_exit) begin
            mode_reg <= dbgsr_pkg::DBGSR_RUN;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------
  // one decode shared by every write path so the offsets cannot drift apart
  function automatic logic wr_hit(logic wr, logic [7:0] addr, logic [7:0] target);
    return wr && (addr == target);
  endfunction : wr_hit
  logic inst_wr;
  logic pc_wr;
  logic status_wr;
  assign inst_wr = wr_hit(reg_wr, reg_addr, `DBGSR_ADDR_INST);
  assign pc_wr = wr_hit(reg_wr, reg_addr, `DBGSR_ADDR_PC);
  // decoded only for checking: no storage sits behind it
  assign status_wr = wr_hit(reg_wr, reg_addr, `DBGSR_ADDR_STATUS);

  // ----------------------------------------------------------------
  // control bits: trap on zero opcode, instruction replace
  // ----------------------------------------------------------------
  logic toz_reg;
  logic irp_reg;
  logic ctrl_wr;
  assign ctrl_wr = wr_hit(reg_wr, reg_addr, `DBGSR_ADDR_CTRL);
  assign zero_hit = toz_reg && instr_retire && (instr_opcode == `DBGSR_ZERO_OPCODE);
  assign zero_opcode_trap = toz_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      toz_reg <= 1'b0;
    end else if (ctrl_wr) begin
      toz_reg <= reg_wdata[`DBGSR_CTRL_TOZ];
    end
  end
  // self-clear after the first fetch past the return; a write in that cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irp_reg <= 1'b0;
    end else if (ctrl_wr) begin
      irp_reg <= reg_wdata[`DBGSR_CTRL_IRP];
    end else if (return_fetch && irp_reg) begin
      irp_reg <= 1'b0;
    end
  end
  assign fetch_from_debug_word = irp_reg && return_fetch;

  // ----------------------------------------------------------------
  // cause bits, latched at entry and cleared on exit
  // ----------------------------------------------------------------
  logic [31:0] cause_reg;
  logic [31:0] cause_next;
  always_comb begin
    cause_next = `DBGSR_RESET_WORD;
    // all simultaneous causes recorded together
    cause_next[`DBGSR_BIT_TBF] = trace_buffer_full_cause;
    cause_next[`DBGSR_BIT_EXT] = evt_fall;
    cause_next[`DBGSR_BIT_REQ] = debug_request;
    cause_next[`DBGSR_BIT_ZOP] = zero_hit;
    cause_next[`DBGSR_BP_LO +: 8] = breakpoint_hit_vector;
    cause_next[`DBGSR_BIT_SLEEP] = core_sleeping;
    cause_next[`DBGSR_BIT_HWB] = hw_breakpoint_cause;
    cause_next[`DBGSR_BIT_SWB] = sw_breakpoint_cause;
    cause_next[`DBGSR_BIT_SSTEP] = single_step_cause;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_reg <= `DBGSR_RESET_WORD;
    end else if (entering) begin
      cause_reg <= cause_next;
    end else if (in_dbg && debug_exit) begin
      cause_reg <= `DBGSR_RESET_WORD;
    end
  end
  // status is pure core state; no write path reaches it
  logic [31:0] status_word;
  always_comb begin
    status_word = cause_reg;
    status_word[`DBGSR_BIT_IDLE] = in_dbg && !dbg_instr_busy;
    status_word[`DBGSR_BIT_IN_DBG] = in_dbg;
  end

  // ----------------------------------------------------------------
  // instruction word and sampled pc
  // ----------------------------------------------------------------
  // no ready: core drains the word faster than the port refills it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_instruction_word <= `DBGSR_RESET_WORD;
    end else if (inst_wr) begin
      debug_instruction_word <= reg_wdata;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_sampled_pc <= `DBGSR_RESET_WORD;
    end else if (pc_wr) begin
      debug_sampled_pc <= reg_wdata;
    end else if (instr_retire && !in_dbg) begin
      debug_sampled_pc <= instr_pc;
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `DBGSR_RESET_WORD;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `DBGSR_ADDR_STATUS: reg_rdata <= status_word;
        `DBGSR_ADDR_INST: reg_rdata <= debug_instruction_word;
        `DBGSR_ADDR_PC: reg_rdata <= debug_sampled_pc;
        `DBGSR_ADDR_CTRL: begin
          reg_rdata <= `DBGSR_RESET_WORD;
          reg_rdata[`DBGSR_CTRL_TOZ] <= toz_reg;
          reg_rdata[`DBGSR_CTRL_IRP] <= irp_reg;
        end
        default: reg_rdata <= `DBGSR_RESET_WORD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_cause_cleared_exit: assert property (in_dbg && debug_exit |=> cause_reg == 32'h0000_0000)
    else $error("cause bits not cleared on exit");
  a_cause_held_halt: assert property (in_dbg && !debug_exit |=> $stable(cause_reg))
    else $error("cause bits changed in debug mode");
  a_tbf_latched: assert property (entering && trace_buffer_full_cause |=> status_word[28])
    else $error("trace full cause lost");
  a_req_latched: assert property (entering && debug_request |=> status_word[26])
    else $error("request cause lost");
  a_bp_vector: assert property (entering |=> status_word[15:8] == $past(breakpoint_hit_vector))
    else $error("breakpoint vector wrong");
  a_idle_flag: assert property (status_word[24] == (status_word[5] && !dbg_instr_busy))
    else $error("idle flag wrong");
  a_monitor_no_dbg: assert property (!in_dbg && monitor_mode |=> !status_word[5])
    else $error("debug flag set in monitor mode");
  a_pc_frozen: assert property (in_dbg && !(reg_wr && reg_addr == 8'h08) |=> $stable(debug_sampled_pc))
    else $error("sampled pc moved in debug mode");
  a_pc_tracks: assert property (!in_dbg && instr_retire && !reg_wr |=> debug_sampled_pc == $past(instr_pc))
    else $error("sampled pc not updated");
  a_irp_clears: assert property (irp_reg && return_fetch && !ctrl_wr |=> !irp_reg)
    else $error("replace bit not self-cleared");
  a_zero_trap: assert property (!in_dbg && !monitor_mode && zero_hit |=> in_dbg && status_word[25])
    else $error("zero opcode did not trap");
  a_status_nowrite: assert property (reg_wr && reg_addr == 8'h00 && !entering && !(in_dbg && debug_exit) |=> $stable(cause_reg))
    else $error("status write had effect");
  // each cause bit follows its own level at entry
  a_ext_latched: assert property (
    entering && evt_fall
    |=> status_word[`DBGSR_BIT_EXT])
    else $error("event-in cause lost");
  a_zop_latched: assert property (
    entering && zero_hit
    |=> status_word[`DBGSR_BIT_ZOP])
    else $error("zero opcode cause lost");
  a_sleep_latched: assert property (
    entering && core_sleeping
    |=> status_word[`DBGSR_BIT_SLEEP])
    else $error("sleep entry cause lost");
  a_hwb_latched: assert property (
    entering && hw_breakpoint_cause
    |=> status_word[`DBGSR_BIT_HWB])
    else $error("hardware breakpoint cause lost");
  a_swb_latched: assert property (
    entering && sw_breakpoint_cause
    |=> status_word[`DBGSR_BIT_SWB])
    else $error("breakpoint instruction cause lost");
  a_sstep_latched: assert property (
    entering && single_step_cause
    |=> status_word[`DBGSR_BIT_SSTEP])
    else $error("single step cause lost");
  a_multi_cause: assert property (
    entering && debug_request && hw_breakpoint_cause
    |=> status_word[`DBGSR_BIT_REQ] && status_word[`DBGSR_BIT_HWB])
    else $error("simultaneous causes not all recorded");
  // mode flags
  a_dbg_flag_set: assert property (
    entering
    |=> status_word[`DBGSR_BIT_IN_DBG])
    else $error("debug flag not set at entry");
  a_dbg_flag_clear: assert property (
    in_dbg && debug_exit
    |=> !status_word[`DBGSR_BIT_IN_DBG])
    else $error("debug flag not cleared at exit");
  a_idle_outside: assert property (
    !in_dbg
    |-> !status_word[`DBGSR_BIT_IDLE])
    else $error("idle flag set outside debug mode");
  // instruction word and sampled pc
  a_inst_write: assert property (
    inst_wr
    |=> debug_instruction_word == $past(reg_wdata))
    else $error("instruction word write lost");
  a_inst_hold: assert property (
    !inst_wr
    |=> $stable(debug_instruction_word))
    else $error("instruction word changed without write");
  a_pc_write_wins: assert property (
    pc_wr
    |=> debug_sampled_pc == $past(reg_wdata))
    else $error("sampled pc write lost");
  // control bits
  a_no_replace: assert property (
    !irp_reg
    |-> !fetch_from_debug_word)
    else $error("replace fetch without replace bit");
  a_trap_off: assert property (
    !toz_reg
    |-> !zero_hit)
    else $error("zero opcode trapped while disabled");
  // read path
  a_read_status: assert property (
    reg_rd && reg_addr == `DBGSR_ADDR_STATUS && !status_wr
    |=> reg_rdata == $past(status_word))
    else $error("status read returned wrong word");
  a_read_unmapped: assert property (
    reg_rd && (reg_addr[1:0] != 2'h0 || reg_addr > `DBGSR_ADDR_CTRL)
    |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  c_sleep_entry: cover property (entering && core_sleeping);
  c_enter: cover property (entering ##[1:20] debug_exit);
  c_multi_cause: cover property (entering && debug_request && hw_breakpoint_cause);
  c_evt_entry: cover property (entering && evt_fall);
  c_irp_fetch: cover property (fetch_from_debug_word);
endmodule : dbgsr_top

// *** test/dbgsr_core_model.sv ***
// core retirement model feeding the debug status block
`timescale 1ns/1ps
module dbgsr_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench controls
  input wire logic run,
  input wire logic zop,
  // retirement stream
  output logic instr_retire,
  output logic [31:0] instr_pc,
  output logic [15:0] instr_opcode,
  output logic [31:0] last_pc
);
  // ------------------------------------------------------------
  // retirement: one per cycle, no stall toward the debug port
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_retire <= 1'b0;
      instr_pc <= 32'h0000_1000;
      instr_opcode <= 16'h5a5a;
      last_pc <= 32'h0000_1000;
    end else if (run) begin
      instr_retire <= 1'b1;
      instr_pc <= last_pc + 32'h0000_0004;
      last_pc <= last_pc + 32'h0000_0004;
      instr_opcode <= zop ? 16'h0000 : 16'h5a5a;
    end else begin
      // stale qualifiers toggle so nothing relies on them
      instr_retire <= 1'b0;
      instr_pc <= ~instr_pc;
      instr_opcode <= ~instr_opcode;
    end
  end
endmodule : dbgsr_core_model

// *** test/tb_top.sv ***
// self-checking bench for the debug status block
`timescale 1ns/1ps
`include "dbgsr_map.svh"
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin bad_count++; \
  $display("wrong value at %0t got %h exp %h", $time, g, x); end end
module tb_top;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, debug_enter = 0, debug_exit = 0;
  logic monitor_mode = 0, trace_buffer_full_cause = 0, event_in_pin = 1, debug_request = 0;
  logic hw_breakpoint_cause = 0, sw_breakpoint_cause = 0, single_step_cause = 0;
  logic core_sleeping = 0, dbg_instr_busy = 0, return_fetch = 0, run = 0, zop = 0;
  logic rd_seen = 0, instr_retire, zero_opcode_trap, fetch_from_debug_word;
  logic [7:0] reg_addr = 0, breakpoint_hit_vector = 0;
  logic [15:0] instr_opcode;
  logic [31:0] reg_wdata = 0, reg_rdata, debug_instruction_word, debug_sampled_pc;
  logic [31:0] instr_pc, last_pc, e, got_e, spc;
  logic [31:0] exp_q[$];
  int bad_count = 0, total_checks = 0;
  always #12.5 clk = ~clk;
  dbgsr_top DUT (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .debug_enter, .debug_exit, .monitor_mode, .trace_buffer_full_cause, .event_in_pin,
    .debug_request, .hw_breakpoint_cause, .breakpoint_hit_vector, .sw_breakpoint_cause,
    .single_step_cause, .core_sleeping, .instr_retire, .instr_pc, .instr_opcode,
    .dbg_instr_busy, .dbg_fetch(1'b0), .return_fetch, .zero_opcode_trap,
    .fetch_from_debug_word, .debug_instruction_word, .debug_sampled_pc);
  dbgsr_core_model core (.clk, .rst_n, .run, .zop, .instr_retire, .instr_pc,
    .instr_opcode, .last_pc);
  // ------------------------------------------------------------
  // bus tasks and read-data monitor
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cyc(1);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    cyc(1);
    reg_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    cyc(1);
    reg_rd = 1;
    reg_addr = a;
    exp_q.push_back(x);
    cyc(1);
    reg_rd = 0;
  endtask : rd
  task automatic enter_exit(input logic ex);
    if (ex) debug_exit = 1;
    else debug_enter = 1;
    cyc(1);
    debug_exit = 0;
    debug_enter = 0;
  endtask : enter_exit
  always @(posedge clk) begin
    if (rd_seen) begin
      got_e = exp_q.pop_front();
      `CHK(reg_rdata, got_e)
    end
    rd_seen <= reg_rd;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #20000;
    bad_count++;
    tally_and_finish();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(68));
    cyc(3);
    rst_n = 1;
    rd(`DBGSR_ADDR_INST, 32'h0000_0000);
    wr(`DBGSR_ADDR_STATUS, 32'hffff_ffff);
    rd(`DBGSR_ADDR_STATUS, 32'h0000_0000);
    e = $urandom;
    wr(`DBGSR_ADDR_INST, e);
    rd(`DBGSR_ADDR_INST, e);
    `CHK(debug_instruction_word, e)
    $display("test 1 done");
    for (int i = 0; i < 4; i++) begin
      {trace_buffer_full_cause, debug_request, hw_breakpoint_cause} = 3'($urandom);
      {sw_breakpoint_cause, single_step_cause, core_sleeping} = 3'($urandom);
      breakpoint_hit_vector = 8'($urandom);
      e = {3'h0, trace_buffer_full_cause, 1'b0, debug_request, 2'h1, 8'h00,
        breakpoint_hit_vector, 3'h1, core_sleeping, 1'b0, hw_breakpoint_cause,
        sw_breakpoint_cause, single_step_cause};
      enter_exit(0);
      // causes forced high and vector inverted after entry: latched copy must not follow
      {trace_buffer_full_cause, debug_request, hw_breakpoint_cause} = 3'h7;
      {sw_breakpoint_cause, single_step_cause, core_sleeping} = 3'h7;
      breakpoint_hit_vector = ~breakpoint_hit_vector;
      rd(`DBGSR_ADDR_STATUS, e);
      enter_exit(1);
      rd(`DBGSR_ADDR_STATUS, 32'h0000_0000);
    end
    {trace_buffer_full_cause, debug_request, hw_breakpoint_cause} = 3'h0;
    {sw_breakpoint_cause, single_step_cause, core_sleeping} = 3'h0;
    breakpoint_hit_vector = 8'h00;
    $display("test 2 done");
    monitor_mode = 1;
    enter_exit(0);
    rd(`DBGSR_ADDR_STATUS, 32'h0000_0000);
    monitor_mode = 0;
    event_in_pin = 0;
    cyc(6);
    event_in_pin = 1;
    rd(`DBGSR_ADDR_STATUS, 32'h0900_0020);
    enter_exit(1);
    $display("test 3 done");
    wr(`DBGSR_ADDR_CTRL, 32'h0200_0000);
    `CHK(zero_opcode_trap, 1'b1)
    run = 1;
    zop = 1;
    cyc(1);
    run = 0;
    cyc(2);
    rd(`DBGSR_ADDR_STATUS, 32'h0300_0020);
    enter_exit(1);
    wr(`DBGSR_ADDR_CTRL, 32'h0000_0000);
    run = 1;
    cyc(1);
    run = 0;
    zop = 0;
    cyc(2);
    rd(`DBGSR_ADDR_STATUS, 32'h0000_0000);
    $display("test 4 done");
    run = 1;
    cyc(5);
    run = 0;
    cyc(2);
    spc = last_pc;
    rd(`DBGSR_ADDR_PC, spc);
    enter_exit(0);
    run = 1;
    cyc(4);
    run = 0;
    dbg_instr_busy = 1;
    rd(`DBGSR_ADDR_PC, spc);
    rd(`DBGSR_ADDR_STATUS, 32'h0000_0020);
    dbg_instr_busy = 0;
    spc = $urandom;
    wr(`DBGSR_ADDR_PC, spc);
    rd(`DBGSR_ADDR_PC, spc);
    enter_exit(1);
    $display("test 5 done");
    wr(`DBGSR_ADDR_CTRL, 32'h0080_0000);
    return_fetch = 1;
    #2;
    `CHK(fetch_from_debug_word, 1'b1)
    cyc(1);
    `CHK(fetch_from_debug_word, 1'b0)
    return_fetch = 0;
    $display("test 6 done");
    cyc(3);
    tally_and_finish();
  end
endmodule : tb_top
